// *** sise_exec.v ***
// Behaviour
// - irq changes exactly the indexed flag
// - clear bit lowers flag instead
// - clear ignores wait, stalls only for its delay
// - wait raises then stalls until lowered
// - three low index bits pick flag
// - relative: add machine id modulo four
// - relative add keeps bit two unchanged
// - flags 0-3 routed to two masked lines
// - delay counts only after wait satisfied
// - set writes immediate to chosen destination
// - set x/y: low five bits, rest zero
// - 000 pins, 001 x, 010 y, 100 dirs, others reserved
// - set pin group separate from out
// - invert is full bitwise complement
// - mov op: none, invert, reverse, reserved
`timescale 1ns/10ps
`default_nettype none
`include "sise_defs.vh"
module sise_exec (
  input wire clock_i, // 25 MHz system clock
  input wire sys_rst_i, // async reset, active high
  input wire ce_i, // clock enable
  input wire instr_valid_i, // instruction presented
  input wire [15:0] instr_i, // instruction word
  input wire [1:0] sm_id_i, // executing machine id
  input wire [31:0] mov_src_i, // mov source word
  input wire [7:0] flag_clr_i, // external flag clear pulses
  input wire [7:0] flag_set_i, // sibling flag set pulses
  input wire [3:0] irq_line0_enable_mask_i, // line 0 enable mask
  input wire [3:0] irq_line1_enable_mask_i, // line 1 enable mask
  input wire [31:0] x_i, // scratch x current value
  input wire [31:0] y_i, // scratch y current value
  output reg [7:0] flags_o, // flag state
  output reg irq_line0_o, // system interrupt line 0
  output reg irq_line1_o, // system interrupt line 1
  output reg [4:0] set_pins_o, // set-group pin levels
  output reg [4:0] set_dirs_o, // set-group pin directions
  output reg [31:0] x_o, // scratch x next value
  output reg [31:0] y_o, // scratch y next value
  output reg xy_we_o, // x/y written this cycle
  output wire stall_o, // instruction not yet retired
  output reg reserved_o, // reserved encoding seen
  output wire [31:0] mov_res_o, // mov result, one cycle later
  output wire mov_op_bad_o // mov reserved op
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_DLY = 2'h2;

  reg [1:0] st_r, st_nxt;
  reg [4:0] dly_r, dly_nxt;
  reg [2:0] wflag_r, wflag_nxt;
  reg [7:0] flags_nxt;
  reg [7:0] irq_set, irq_clr;
  reg [4:0] pins_nxt, dirs_nxt;
  reg [31:0] x_nxt, y_nxt;
  reg we_nxt, rsv_nxt;
  wire [2:0] op = instr_i[`SISE_OP_MSB:`SISE_OP_LSB];
  wire [4:0] imm = instr_i[`SISE_DATA_MSB:`SISE_DATA_LSB];
  wire [2:0] dst = instr_i[`SISE_DST_MSB:`SISE_DST_LSB];
  wire [4:0] dly = instr_i[`SISE_DLY_MSB:`SISE_DLY_LSB];
  wire accept = instr_valid_i && (st_r == ST_IDLE);
  wire is_irq = accept && (op == `SISE_OP_IRQ) && !instr_i[`SISE_IRQ_ZERO_BIT];
  wire is_set = accept && (op == `SISE_OP_SET);
  wire is_clr = instr_i[`SISE_IRQ_CLR_BIT];
  wire is_wait = instr_i[`SISE_IRQ_WAIT_BIT] && !is_clr;

  // flag number: bit 2 direct, low two bits optionally offset by id
  function [2:0] sise_flag_idx;
    input [4:0] idx;
    input [1:0] id;
    reg [1:0] lo;
    begin
      lo = idx[1:0] + (idx[`SISE_IRQ_REL_BIT] ? id : 2'h0);
      sise_flag_idx = {idx[`SISE_IRQ_GRP_BIT], lo};
    end
  endfunction

  wire [2:0] fnum = sise_flag_idx(imm, sm_id_i);

  // a system line is the OR of the enabled low-group flags; the upper group never leaves
  function sise_irq_line;
    input [7:0] fl;
    input [3:0] mask;
    begin
      sise_irq_line = |(fl[`SISE_SYS_FLAG_MSB:`SISE_SYS_FLAG_LSB] & mask);
    end
  endfunction

  // scratch writes keep only the immediate; everything above it reads zero
  function [31:0] sise_zext_imm;
    input [4:0] v;
    begin
      sise_zext_imm = {`SISE_IMM_PAD, v};
    end
  endfunction

  always @* begin
    irq_set = flag_set_i;
    irq_clr = flag_clr_i;
    if (is_irq) begin
      if (is_clr) begin
        irq_clr[fnum] = 1'b1;
      end else begin
        irq_set[fnum] = 1'b1;
      end
    end
    // a set in the same cycle as a clear wins, so a flag raised by a sibling
    // is never lost to an acknowledge aimed at its previous raise
    flags_nxt = (flags_o & ~irq_clr) | irq_set;
  end

  always @* begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    wflag_nxt = wflag_r;
    case (st_r)
      ST_IDLE: begin
        if (is_irq && is_wait) begin
          st_nxt = ST_WAIT;
          wflag_nxt = fnum;
        end else if (accept && (dly != `SISE_DLY_RST)) begin
          st_nxt = ST_DLY;
          dly_nxt = dly;
        end
      end
      ST_WAIT: begin
        // leave only on the registered flag: the clear must have landed,
        // and a set that coincided with it keeps the machine waiting
        if (!flags_o[wflag_r]) begin
          if (dly_r != `SISE_DLY_RST) begin
            st_nxt = ST_DLY;
          end else begin
            st_nxt = ST_IDLE;
          end
        end
      end
      ST_DLY: begin
        dly_nxt = dly_r - `SISE_DLY_STEP;
        if (dly_r == `SISE_DLY_LAST) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // the delay field is latched at acceptance, since the word may change during the wait
    if (st_r == ST_IDLE && is_irq && is_wait) begin
      dly_nxt = dly; // held until wait ends
    end
  end

  // a waiting irq must stall in its own acceptance cycle already,
  // otherwise the fetch would advance before the wait state is entered
  assign stall_o = (st_r != ST_IDLE) || (is_irq && is_wait);

  always @* begin
    pins_nxt = set_pins_o;
    dirs_nxt = set_dirs_o;
    x_nxt = x_i;
    y_nxt = y_i;
    we_nxt = 1'b0;
    rsv_nxt = 1'b0;
    if (is_set) begin
      case (dst)
        `SISE_DST_PINS: pins_nxt = imm;
        `SISE_DST_X: begin
          x_nxt = sise_zext_imm(imm);
          we_nxt = 1'b1;
        end
        `SISE_DST_Y: begin
          y_nxt = sise_zext_imm(imm);
          we_nxt = 1'b1;
        end
        `SISE_DST_PINDIRS: dirs_nxt = imm;
        // reserved codes touch no destination and are only reported
        default: rsv_nxt = 1'b1;
      endcase
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= ST_IDLE;
      dly_r <= `SISE_DLY_RST;
      wflag_r <= `SISE_WFLAG_RST;
      flags_o <= `SISE_FLAGS_RST;
      irq_line0_o <= 1'b0;
      irq_line1_o <= 1'b0;
      set_pins_o <= `SISE_PINS_RST;
      set_dirs_o <= `SISE_DIRS_RST;
      x_o <= `SISE_XY_RST;
      y_o <= `SISE_XY_RST;
      xy_we_o <= 1'b0;
      reserved_o <= 1'b0;
    end else if (ce_i) begin
      // with ce_i low every register, wait and delay state included, holds
      st_r <= st_nxt;
      dly_r <= dly_nxt;
      wflag_r <= wflag_nxt;
      flags_o <= flags_nxt;
      irq_line0_o <= sise_irq_line(flags_nxt, irq_line0_enable_mask_i);
      irq_line1_o <= sise_irq_line(flags_nxt, irq_line1_enable_mask_i);
      set_pins_o <= pins_nxt;
      set_dirs_o <= dirs_nxt;
      x_o <= x_nxt;
      y_o <= y_nxt;
      xy_we_o <= we_nxt;
      reserved_o <= rsv_nxt;
    end
  end

  // the alu runs every enabled cycle; only a mov makes use of its result
  sise_mov_alu u_alu (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .op_i(instr_i[`SISE_MOV_OP_MSB:`SISE_MOV_OP_LSB]),
    .src_i(mov_src_i),
    .res_o(mov_res_o),
    .op_bad_o(mov_op_bad_o)
  );
endmodule
`default_nettype wire

// *** sise_defs.vh ***
`ifndef SISE_DEFS_VH
`define SISE_DEFS_VH
`define SISE_OP_MSB 15
`define SISE_OP_LSB 13
`define SISE_OP_IRQ 3'h6
`define SISE_OP_SET 3'h7
`define SISE_OP_MOV 3'h5
`define SISE_DLY_MSB 12
`define SISE_DLY_LSB 8
`define SISE_IRQ_ZERO_BIT 7
`define SISE_IRQ_CLR_BIT 6
`define SISE_IRQ_WAIT_BIT 5
`define SISE_IRQ_REL_BIT 4
`define SISE_IRQ_GRP_BIT 2
`define SISE_DST_MSB 7
`define SISE_DST_LSB 5
`define SISE_DATA_MSB 4
`define SISE_DATA_LSB 0
`define SISE_MOV_OP_MSB 4
`define SISE_MOV_OP_LSB 3
`define SISE_DST_PINS 3'h0
`define SISE_DST_X 3'h1
`define SISE_DST_Y 3'h2
`define SISE_DST_PINDIRS 3'h4
`define SISE_MOVOP_NONE 2'h0
`define SISE_MOVOP_INV 2'h1
`define SISE_MOVOP_REV 2'h2
`define SISE_PINS_RST 5'h00
`define SISE_DIRS_RST 5'h00
`define SISE_FLAGS_RST 8'h00
`define SISE_DLY_RST 5'h00
`define SISE_DLY_STEP 5'h01
`define SISE_DLY_LAST 5'h01
`define SISE_WFLAG_RST 3'h0
`define SISE_XY_RST 32'h0000_0000
`define SISE_IMM_PAD 27'h0000000
`define SISE_SYS_FLAG_MSB 3
`define SISE_SYS_FLAG_LSB 0
`endif

// *** sise_mov_alu.v ***
`timescale 1ns/10ps
`default_nettype none
`include "sise_defs.vh"
module sise_mov_alu (
  input wire clock_i, // system clock
  input wire sys_rst_i, // async reset
  input wire ce_i, // clock enable
  input wire [1:0] op_i, // mov operation field
  input wire [31:0] src_i, // source word
  output reg [31:0] res_o, // registered result
  output reg op_bad_o // registered: reserved op seen
);
  function [31:0] sise_rev;
    input [31:0] v;
    integer k;
    begin
      for (k = 0; k < 32; k = k + 1) begin
        sise_rev[k] = v[31-k];
      end
    end
  endfunction
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      res_o <= 32'h0000_0000;
      op_bad_o <= 1'b0;
    end else if (ce_i) begin
      op_bad_o <= 1'b0;
      case (op_i)
        `SISE_MOVOP_NONE: res_o <= src_i;
        `SISE_MOVOP_INV: res_o <= ~src_i;
        `SISE_MOVOP_REV: res_o <= sise_rev(src_i);
        default: begin
          res_o <= src_i;
          op_bad_o <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sise_exec_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module sise_exec_monitor (
  input wire logic clock_i, // clk
  input wire logic sys_rst_i, // rst
  input wire logic ce_i, // en
  input wire logic instr_valid_i, // valid
  input wire logic [15:0] instr_i, // word
  input wire logic [7:0] flag_clr_i, // clr
  input wire logic [7:0] flag_set_i, // sibling set
  input wire logic [3:0] irq_line0_enable_mask_i, // mask
  input wire logic [31:0] mov_src_i, // src
  input wire logic [7:0] flags_o, // flags
  input wire logic irq_line0_o, // line
  input wire logic [4:0] set_pins_o, // pins
  input wire logic [4:0] set_dirs_o, // dirs
  input wire logic [31:0] x_o, // x
  input wire logic xy_we_o, // we
  input wire logic stall_o, // stall
  input wire logic reserved_o, // rsv
  input wire logic [31:0] mov_res_o // res
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  wire tk = ce_i && instr_valid_i && !stall_o;
  wire [2:0] d = instr_i[7:5];
  wire st = tk && instr_i[15:13] == 3'h7;
  wire iq = tk && instr_i[15:13] == 3'h6 && !instr_i[7] && !instr_i[4] && !flag_clr_i && !flag_set_i;
  property p_sx; st && d == 3'h1 |=> xy_we_o && x_o == {27'h0, $past(instr_i[4:0])}; endproperty
  a_sx: assert property (p_sx) else $error("set x");
  property p_sp; st && d == 3'h0 |=> set_pins_o == $past(instr_i[4:0]); endproperty
  a_sp: assert property (p_sp) else $error("set pins");
  property p_sd; st && d == 3'h4 |=> set_dirs_o == $past(instr_i[4:0]); endproperty
  a_sd: assert property (p_sd) else $error("set dirs");
  property p_sr; st && d == 3'h3 |=> reserved_o && $stable(set_pins_o) && $stable(set_dirs_o); endproperty
  a_sr: assert property (p_sr) else $error("reserved dst");
  property p_inv; ce_i && instr_i[4:3] == 2'h1 |=> mov_res_o == ~$past(mov_src_i); endproperty
  a_inv: assert property (p_inv) else $error("invert");
  property p_is; iq && !instr_i[6] |=> flags_o[$past(instr_i[2:0])]; endproperty
  a_is: assert property (p_is) else $error("flag set");
  property p_ic; iq && instr_i[6] |=> !flags_o[$past(instr_i[2:0])]; endproperty
  a_ic: assert property (p_ic) else $error("flag clear");
  property p_l0; $past(ce_i) |-> irq_line0_o == |(flags_o[3:0] & $past(irq_line0_enable_mask_i)); endproperty
  a_l0: assert property (p_l0) else $error("line 0");
  c_wt: cover property (stall_o && flags_o[5]);
  c_rl: cover property (tk && instr_i[15:13] == 3'h6 && instr_i[4]);
  c_rs: cover property (reserved_o);
endmodule
bind sise_exec sise_exec_monitor u_mon (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .flag_clr_i(flag_clr_i), .flag_set_i(flag_set_i),
  .irq_line0_enable_mask_i(irq_line0_enable_mask_i), .mov_src_i(mov_src_i), .flags_o(flags_o),
  .irq_line0_o(irq_line0_o), .set_pins_o(set_pins_o), .set_dirs_o(set_dirs_o), .x_o(x_o), .xy_we_o(xy_we_o),
  .stall_o(stall_o), .reserved_o(reserved_o), .mov_res_o(mov_res_o));
`default_nettype wire

// *** sise_handler.sv ***
`timescale 1ns/10ps
`default_nettype none
module sise_handler (
  input wire logic clock_i, // clk
  input wire logic sys_rst_i, // rst
  input wire logic [7:0] flags_i, // flags
  input wire logic [7:0] ack_en_i, // owned flags
  input wire logic [2:0] lat_i, // ack delay
  output logic [7:0] flag_clr_o // ack pulse
);
  logic [2:0] cnt_r;
  // acknowledges owned flags once they have been seen for lat_i + 1 cycles
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      {cnt_r, flag_clr_o} <= 11'h000;
    else begin
      cnt_r <= |(flags_i & ack_en_i) ? cnt_r + 3'h1 : 3'h0;
      flag_clr_o <= cnt_r == lat_i ? flags_i & ack_en_i : 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock_i = 0, sys_rst_i = 1, ce_i = 1, instr_valid_i = 0, irq_line0_o, irq_line1_o, xy_we_o, stall_o;
  logic reserved_o, mov_op_bad_o;
  logic [1:0] sm_id_i = 0;
  logic [2:0] lat = 0;
  logic [3:0] irq_line0_enable_mask_i = 0, irq_line1_enable_mask_i = 0;
  logic [4:0] set_pins_o, set_dirs_o, ep = 0, ed = 0;
  logic [7:0] flag_set_i = 0, flag_clr_i, flags_o, ack = 0, ef = 0;
  logic [15:0] instr_i = 0;
  logic [31:0] mov_src_i = 0, x_i = 0, y_i = 0, x_o, y_o, mov_res_o, e;
  int errors = 0, comparisons = 0, i, f, n;
  initial forever #20 clock_i = ~clock_i;
  sise_exec dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .sm_id_i(sm_id_i), .mov_src_i(mov_src_i), .flag_clr_i(flag_clr_i),
    .flag_set_i(flag_set_i), .irq_line0_enable_mask_i(irq_line0_enable_mask_i),
    .irq_line1_enable_mask_i(irq_line1_enable_mask_i), .x_i(x_i), .y_i(y_i), .flags_o(flags_o),
    .irq_line0_o(irq_line0_o), .irq_line1_o(irq_line1_o), .set_pins_o(set_pins_o), .set_dirs_o(set_dirs_o),
    .x_o(x_o), .y_o(y_o), .xy_we_o(xy_we_o), .stall_o(stall_o), .reserved_o(reserved_o),
    .mov_res_o(mov_res_o), .mov_op_bad_o(mov_op_bad_o));
  sise_handler u_hnd (.clock_i, .sys_rst_i, .flags_i(flags_o), .ack_en_i(ack), .lat_i(lat), .flag_clr_o(flag_clr_i));
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task go(input logic [15:0] w);
    instr_i = w;
    instr_valid_i = 1;
    @(posedge clock_i);
    #1;
  endtask
  task close_out;
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // the run needs well under two hundred cycles; this leaves wide margin
  initial begin
    #200000;
    errors++;
    close_out;
  end
  initial begin
    n = $urandom(99);
    repeat (6) @(posedge clock_i);
    #1 sys_rst_i = 0;
    for (i = 0; i < 40; i++) begin
      n = $urandom;
      {x_i, y_i} = {$urandom, $urandom};
      go({8'he0, n[7:0]});
      if (n[7:5] == 3'h0) ep = n[4:0];
      if (n[7:5] == 3'h4) ed = n[4:0];
      chk("pins", ep, set_pins_o);
      chk("dirs", ed, set_dirs_o);
      chk("x", n[7:5] == 3'h1 ? n[4:0] : x_i, x_o);
      chk("y", n[7:5] == 3'h2 ? n[4:0] : y_i, y_o);
      chk("we", n[7:5] == 3'h1 || n[7:5] == 3'h2, xy_we_o);
      chk("rsv", n[7:5] == 3'h3 || n[7:5] > 3'h4, reserved_o);
    end
    for (i = 0; i < 60; i++) begin
      n = $urandom;
      {sm_id_i, irq_line1_enable_mask_i, irq_line0_enable_mask_i} = n[19:10];
      f = n[4] ? {n[2], n[1:0] + sm_id_i} : n[2:0];
      go({8'hc0, n[7:6], n[6] & n[5], n[4:0]});
      if (!n[7]) ef[f] = !n[6];
      chk("flags", ef, flags_o);
      chk("irq0", |(ef[3:0] & irq_line0_enable_mask_i), irq_line0_o);
      chk("irq1", |(ef[3:0] & irq_line1_enable_mask_i), irq_line1_o);
      chk("stall", 0, stall_o);
    end
    for (i = 0; i < 4; i++) begin
      mov_src_i = $urandom;
      go({11'h500, i[1:0], 3'h1});
      for (f = 0; f < 32; f++) e[f] = mov_src_i[31 - f];
      chk("mov", i == 1 ? ~mov_src_i : i == 2 ? e : mov_src_i, mov_res_o);
      chk("mov_bad", i == 3, mov_op_bad_o);
    end
    ce_i = 0;
    go(16'he015);
    chk("frozen", ep, set_pins_o);
    ce_i = 1;
    go(16'he30a);
    instr_valid_i = 0;
    ep = 5'h0a;
    chk("pins", ep, set_pins_o);
    for (n = 0; stall_o && n < 30; n++) begin
      @(posedge clock_i);
      #1;
    end
    chk("delay", 3, n);
    go(16'hc045);
    ef[5] = 0;
    ack = 8'h20;
    for (i = 0; i < 2; i++) begin
      lat = i ? 3'h4 : 3'h0;
      go(16'hc225);
      instr_valid_i = 0;
      chk("wait_set", 3, {flags_o[5], stall_o});
      for (n = 0; stall_o && n < 30; n++) begin
        if (flags_o[5]) f = n;
        @(posedge clock_i);
        #1;
      end
      chk("delay", 4, n - f);
    end
    flag_set_i = 8'h80;
    ef[7] = 1;
    go(16'hc047);
    flag_set_i = 0;
    instr_valid_i = 0;
    chk("flags", ef, flags_o);
    chk("irq0", |(ef[3:0] & irq_line0_enable_mask_i), irq_line0_o);
    chk("irq1", |(ef[3:0] & irq_line1_enable_mask_i), irq_line1_o);
    close_out;
  end
endmodule
`default_nettype wire
